// ### logic/asp_sram_ctrl.sv
`timescale 1ns/1ps
`include "asp_defs.svh"

// Summary of operation
// R1: Controller drives a 15-bit word address for every access.
// R2: Memory data bus is 16 bits, input on writes, output on reads.
// R3: Write strobe low with chip selected performs a write.
// R4: Write strobe high with chip selected performs a read.
// R5: Memory responds only while chip select is low.
// R6: Upper byte enable gates bits 15..8, lower enable bits 7..0.
// R7: Memory drives data only while output enable is low in a read.
// R8: Output enable high floats memory data lines.
// R9: Each read cycle lasts at least 10 ns.
// R10: Read data valid 10 ns after address or select.
// R11: Old read data held 3 ns after address change.
// R12: Read data valid 5 ns after output enable falls.
// R13: Lane data valid or floated 5 ns after byte enable change.
// R14: Data released 5 ns after output enable rises.
// R15: Released 5 ns after select rises; not driven before 3 ns after fall.
// R16: Floated 5 ns after strobe falls; not driven before 3 ns after rise.
// R17: Each write cycle lasts at least 10 ns.
// R18: Select low 8 ns before write end, strobe low at least 7 ns.
// R19: Byte enables asserted at least 7 ns before write end.
// R20: Address stable 7 ns before write end, set up at start, held after.
// R21: Write data valid 5 ns before write end, held after.
// R22: Write spans overlap of select, strobe, lane; first rise ends it.
// R23: No lanes enabled, or OE and strobe high, keeps data floated.
// R24: Strobe pulse with OE low covers data setup plus release time.
module asp_sram_ctrl
   import asp_pkg::*;
#(
   parameter int READ_CYC  = `ASP_CYC_UP(`ASP_ADDR_TO_DATA_MAX_NS) + `ASP_SAMPLE_MARGIN
                             + `ASP_SYNC_STAGES,
   parameter int WRITE_CYC = `ASP_CYC_UP(`ASP_STROBE_PULSE_MIN_NS
                                         + `ASP_STROBE_REL_MAX_NS)
)(
   input  wire logic                   sys_clk,
   input  wire logic                   nrst,
   input  wire logic                   req_valid,
   input  wire asp_req_t               req,
   output logic                        req_ready,
   output logic                        rsp_valid,
   output logic [`ASP_DATA_W-1:0]      rsp_data,
   output logic [`ASP_ADDR_W-1:0]      word_addr,
   output asp_ctl_t                    ctl,
   output logic [`ASP_DATA_W-1:0]      data_bus_out,
   output logic                        data_bus_oe,
   input  wire logic [`ASP_DATA_W-1:0] data_bus_in
);
   // Counter wide enough for the longest access
   localparam int            CW       = `ASP_CNT_W;
   localparam logic [CW-1:0] RD_CNT   = CW'(READ_CYC);
   localparam logic [CW-1:0] WR_CNT   = CW'(WRITE_CYC);
   localparam asp_ctl_t      CTL_IDLE = '{
      sel_n:           1'h1,
      we_n:            1'h1,
      oe_n:            1'h1,
      upper_byte_en_n: 1'h1,
      lower_byte_en_n: 1'h1
   };

   // Sequence group: strobes, direction, handshake
   asp_state_t               state_r, state_nxt;
   logic [CW-1:0]            cnt_r, cnt_nxt;
   asp_ctl_t                 ctl_r, ctl_nxt;
   logic                     oe_r, oe_nxt;
   logic                     ready_r, ready_nxt;
   logic                     rsp_r, rsp_nxt;

   // Data group: captured request and read word
   logic [`ASP_ADDR_W-1:0]   addr_r, addr_nxt;
   logic [`ASP_DATA_W-1:0]   wdata_r, wdata_nxt;
   logic [`ASP_DATA_W-1:0]   rdata_r, rdata_nxt;

   // Pin synchroniser; only the second stage feeds logic
   logic [`ASP_DATA_W-1:0]   din_s1_r, din_s1_nxt;
   logic [`ASP_DATA_W-1:0]   din_s2_r, din_s2_nxt;

   // Events shared by the groups
   logic                     take;
   logic                     last_cyc;
   logic                     rd_done;

   assign take     = req_valid && ready_r && (state_r == ST_IDLE);
   assign last_cyc = (cnt_r == `ASP_ONE);
   assign rd_done  = (state_r == ST_READ) && last_cyc;

   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      ctl_nxt   = ctl_r;
      oe_nxt    = oe_r;
      ready_nxt = ready_r;
      // Response is a one-cycle pulse
      rsp_nxt   = 1'h0;
      case (state_r)
         ST_IDLE: begin
            if (take) begin
               ready_nxt               = 1'h0;
               ctl_nxt.sel_n           = 1'h0;          // [R5]
               ctl_nxt.upper_byte_en_n = req.lane_n[1]; // [R6] [R19]
               ctl_nxt.lower_byte_en_n = req.lane_n[0]; // [R6]
               if (req.write) begin
                  // OE stays high so the memory never fights our drive
                  ctl_nxt.we_n = 1'h0;                  // [R3] [R18] [R23]
                  ctl_nxt.oe_n = 1'h1;
                  oe_nxt       = 1'h1;                  // [R2] [R8]
                  cnt_nxt      = WR_CNT;
                  state_nxt    = ST_WRITE;
               end else begin
                  ctl_nxt.we_n = 1'h1;                  // [R4]
                  ctl_nxt.oe_n = 1'h0;                  // [R7] [R12]
                  oe_nxt       = 1'h0;
                  cnt_nxt      = RD_CNT;
                  state_nxt    = ST_READ;
               end
            end
         end
         ST_READ: begin
            // Held past access time plus both sync stages; slower but safe
            cnt_nxt = cnt_r - `ASP_ONE;                 // [R9] [R10]
            if (last_cyc) begin
               rsp_nxt   = 1'h1;
               ctl_nxt   = CTL_IDLE;                    // [R14] [R15]
               cnt_nxt   = `ASP_ONE;
               state_nxt = ST_REC;
            end
         end
         ST_WRITE: begin
            cnt_nxt = cnt_r - `ASP_ONE;                 // [R17] [R24]
            if (last_cyc) begin
               // All enables rise together; data and address held one more cycle
               ctl_nxt   = CTL_IDLE;                    // [R22] [R16]
               cnt_nxt   = `ASP_ONE;
               state_nxt = ST_REC;
            end
         end
         ST_REC: begin
            // Bus turnaround; write data hold after write end
            oe_nxt    = 1'h0;                           // [R21] [R11]
            ready_nxt = 1'h1;
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
            ctl_nxt   = CTL_IDLE;
            oe_nxt    = 1'h0;
            ready_nxt = 1'h1;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         state_r <= ST_IDLE;
         cnt_r   <= `ASP_ZERO;
         ctl_r   <= CTL_IDLE;
         oe_r    <= 1'h0;
         ready_r <= 1'h1;
         rsp_r   <= 1'h0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         ctl_r   <= ctl_nxt;
         oe_r    <= oe_nxt;
         ready_r <= ready_nxt;
         rsp_r   <= rsp_nxt;
      end
   end

   // Captured at take so the pins hold steady through the whole access
   always_comb begin
      addr_nxt  = addr_r;
      wdata_nxt = wdata_r;
      rdata_nxt = rdata_r;
      if (take) begin
         addr_nxt  = req.addr;                          // [R1] [R20]
         wdata_nxt = req.wdata;                         // [R21]
      end
      // Word stands until the next read completes
      if (rd_done) begin
         rdata_nxt = din_s2_r;                          // [R13]
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         addr_r  <= '0;
         wdata_r <= '0;
         rdata_r <= '0;
      end else begin
         addr_r  <= addr_nxt;
         wdata_r <= wdata_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   always_comb begin
      din_s1_nxt = data_bus_in;
      din_s2_nxt = din_s1_r;
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         din_s1_r <= '0;
         din_s2_r <= '0;
      end else begin
         din_s1_r <= din_s1_nxt;
         din_s2_r <= din_s2_nxt;
      end
   end

   // Outputs come straight from registers
   assign req_ready    = ready_r;
   assign rsp_valid    = rsp_r;
   assign rsp_data     = rdata_r;
   assign word_addr    = addr_r;
   assign ctl          = ctl_r;
   assign data_bus_out = wdata_r;
   assign data_bus_oe  = oe_r;

endmodule : asp_sram_ctrl

// ### logic/asp_defs.svh
`ifndef ASP_DEFS_SVH
`define ASP_DEFS_SVH

// Timing figures in ns, fastest grade
`define ASP_CLK_PERIOD_NS        5
`define ASP_READ_CYCLE_MIN_NS    10
`define ASP_ADDR_TO_DATA_MAX_NS  10
`define ASP_OE_TO_DATA_MAX_NS    5
`define ASP_OE_RELEASE_MAX_NS    5
`define ASP_WRITE_CYCLE_MIN_NS   10
`define ASP_SELECT_TO_WEND_NS    8
`define ASP_STROBE_PULSE_MIN_NS  7
`define ASP_LANE_TO_WEND_NS      7
`define ASP_ADDR_SETUP_WEND_NS   7
`define ASP_WDATA_SETUP_NS       5
`define ASP_STROBE_REL_MAX_NS    5

// Least times round up to whole cycles
`define ASP_CYC_UP(ns) (((ns) + `ASP_CLK_PERIOD_NS - 1) / `ASP_CLK_PERIOD_NS)

// Read data crosses two flops; one spare cycle keeps the first stage off the edge
`define ASP_SYNC_STAGES   2
`define ASP_SAMPLE_MARGIN 1

`define ASP_ADDR_W 15
`define ASP_DATA_W 16
`define ASP_CNT_W  4
`define ASP_ONE    4'h1
`define ASP_ZERO   4'h0

`endif

// ### logic/asp_pkg.sv
package asp_pkg;
   typedef struct packed {
      logic        write;
      logic [1:0]  lane_n;
      logic [14:0] addr;
      logic [15:0] wdata;
   } asp_req_t;

   typedef struct packed {
      logic        sel_n;
      logic        we_n;
      logic        oe_n;
      logic        upper_byte_en_n;
      logic        lower_byte_en_n;
   } asp_ctl_t;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_READ  = 4'b0010,
      ST_WRITE = 4'b0100,
      ST_REC   = 4'b1000
   } asp_state_t;
endpackage : asp_pkg

// ### sim/asp_sram_monitor.sv
`timescale 1ns/1ps
module asp_sram_monitor
   import asp_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        nrst,
   input wire logic        req_valid,
   input wire asp_req_t    req,
   input wire logic        req_ready,
   input wire logic        rsp_valid,
   input wire logic [14:0] word_addr,
   input wire asp_ctl_t    ctl,
   input wire logic [15:0] data_bus_out,
   input wire logic        data_bus_oe
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   wire tk = req_valid && req_ready;
   a_read_window: assert property (tk && !req.write |=>
      (!ctl.sel_n && ctl.we_n && !ctl.oe_n)[*5] ##1 ctl.sel_n) else $error("read window");
   a_read_answer: assert property (tk && !req.write |-> ##6 rsp_valid)
      else $error("no read answer");
   a_write_strobe: assert property (tk && req.write |=>
      (!ctl.sel_n && !ctl.we_n)[*3] ##1 (ctl.sel_n && ctl.we_n)) else $error("strobe");
   a_addr_lanes: assert property (tk |=> word_addr == $past(req.addr) &&
      {ctl.upper_byte_en_n, ctl.lower_byte_en_n} == $past(req.lane_n) ##1
      $stable(word_addr)[*3]) else $error("address or lanes");
   a_wdata_hold: assert property (tk && req.write |=> data_bus_out == $past(req.wdata)
      ##0 data_bus_oe[*4] ##1 !data_bus_oe) else $error("write data");
   a_oe_in_write: assert property (!ctl.we_n |-> ctl.oe_n && data_bus_oe)
      else $error("oe in write");
   a_no_clash: assert property (!ctl.oe_n |-> !data_bus_oe)
      else $error("bus clash");
   a_ready_gap: assert property (tk && req.write |=> !req_ready[*4] ##1 req_ready)
      else $error("ready gap");
   a_read_gap: assert property (tk && !req.write |=> !req_ready[*6] ##1 req_ready)
      else $error("read ready gap");
endmodule : asp_sram_monitor

bind asp_sram_ctrl asp_sram_monitor i_mon (.sys_clk, .nrst, .req_valid, .req, .req_ready,
   .rsp_valid, .word_addr, .ctl, .data_bus_out, .data_bus_oe);

// ### sim/asp_sram_model.sv
`timescale 1ns/1ps
module asp_sram_model
   import asp_pkg::*;
#(parameter int DLY = 10)( // Worst access time, so an early sample sees inverted data
   input  wire logic [14:0] word_addr,
   input  wire asp_ctl_t    ctl,
   input  wire logic [15:0] data_bus_out,
   input  wire logic        data_bus_oe,
   output wire logic [15:0] data_bus_in
);
   logic [15:0] mem [0:32767] = '{default: 16'h0000};
   logic [1:0]  ln_q;
   wire         wr = !ctl.sel_n && !ctl.we_n;
   wire         rd = !ctl.sel_n && ctl.we_n && !ctl.oe_n;
   wire  [15:0] q = mem[word_addr];
   wire  [15:0] d = data_bus_oe ? data_bus_out : ~data_bus_out;
   always @(ctl) if (!ctl.sel_n && !ctl.we_n) ln_q = {ctl.upper_byte_en_n, ctl.lower_byte_en_n};
   always @(negedge wr) begin
      if (!ln_q[1]) mem[word_addr][15:8] = d[15:8];
      if (!ln_q[0]) mem[word_addr][7:0] = d[7:0];
   end
   // Idle lanes show inverted data, so a stale sample cannot pass
   assign #(DLY) data_bus_in = {(rd && !ctl.upper_byte_en_n) ? q[15:8] : ~q[15:8],
      (rd && !ctl.lower_byte_en_n) ? q[7:0] : ~q[7:0]};
endmodule : asp_sram_model

// ### sim/async_sram_32kx16_port_tb_top.sv
`timescale 1ns/1ps
module async_sram_32kx16_port_tb_top;
   import asp_pkg::*;
   logic        sys_clk = 1'h0;
   logic        nrst = 1'h0;
   logic        req_valid = 1'h0;
   asp_req_t    req = '0;
   logic        req_ready, rsp_valid, data_bus_oe;
   logic [15:0] rsp_data, data_bus_out;
   wire  [15:0] data_bus_in;
   logic [14:0] word_addr;
   asp_ctl_t    ctl;
   int          fail_count = 0;
   int          tests_run = 0;
   int          cyc = 0;
   logic [49:0] rows [8] = '{{1'h1, 2'h0, 15'h7FFF, 16'h1234, 16'h0000},
      {1'h1, 2'h0, 15'h0000, 16'hABCD, 16'h0000}, {1'h0, 2'h0, 15'h7FFF, 16'h0000, 16'h1234},
      {1'h1, 2'h2, 15'h7FFF, 16'h5566, 16'h0000}, {1'h1, 2'h1, 15'h0000, 16'h7788, 16'h0000},
      {1'h1, 2'h3, 15'h0000, 16'hFFFF, 16'h0000}, {1'h0, 2'h0, 15'h7FFF, 16'h0000, 16'h1266},
      {1'h0, 2'h0, 15'h0000, 16'h0000, 16'h77CD}};
   asp_sram_ctrl i_asp_sram_ctrl (.sys_clk, .nrst, .req_valid, .req, .req_ready, .rsp_valid,
      .rsp_data, .word_addr, .ctl, .data_bus_out, .data_bus_oe, .data_bus_in);
   asp_sram_model i_asp_sram_model (.word_addr, .ctl, .data_bus_out, .data_bus_oe, .data_bus_in);
   initial forever #2.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 500) begin
         fail_count++;
         final_report;
      end
   end
   task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
      tests_run++;
      if (s !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   // Request is held while ready is low, then dropped after the take
   task automatic acc(input asp_req_t r, input logic [15:0] e);
      logic [15:0] m;
      int          n;
      m = {{8{~r.lane_n[1]}}, {8{~r.lane_n[0]}}};
      @(negedge sys_clk);
      req = r;
      req_valid = 1'h1;
      n = 0;
      while (req_ready !== 1'h1 && n < 20) begin
         @(negedge sys_clk);
         n++;
      end
      @(negedge sys_clk);
      req_valid = 1'h0;
      n = 0;
      while (!r.write && rsp_valid !== 1'h1 && n < 8) begin
         @(negedge sys_clk);
         n++;
      end
      if (!r.write) chk("rsp_valid", 16'(rsp_valid), 16'h0001);
      if (!r.write) chk("rsp_data", rsp_data & m, e & m);
   endtask : acc
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : final_report
   initial begin
      repeat (2) @(negedge sys_clk);
      nrst = 1'h1;
      for (int i = 0; i < 8; i++) begin
         acc(rows[i][49:16], rows[i][15:0]);
         $display("row %0d done", i);
      end
      acc({1'h1, 2'h0, 15'h0000, 16'h0F0F}, 16'h0000);
      @(negedge sys_clk);
      nrst = 1'h0;
      @(negedge sys_clk);
      chk("ctl", 16'(ctl), 16'h001F);
      chk("data_bus_oe", 16'(data_bus_oe), 16'h0000);
      nrst = 1'h1;
      acc({1'h0, 2'h0, 15'h7FFF, 16'h0000}, 16'h1266);
      $display("reset test done");
      final_report;
   end
endmodule : async_sram_32kx16_port_tb_top
